/* core/ulsc_pkg.sv */
package ulsc_pkg;
    // Clock and bit timing
    localparam int CLK_HZ = 20_000_000;
    localparam int FS_BIT_HZ = 2_000_000;
    localparam int LS_BIT_HZ = 1_000_000;
    localparam int FS_BIT_CYC = CLK_HZ / FS_BIT_HZ;
    localparam int LS_BIT_CYC = CLK_HZ / LS_BIT_HZ;
    // Line-state durations in their own units
    localparam int RESET_MS = 10;
    localparam int RESET_ACCEPT_NS = 2500;
    localparam int DISC_NS = 2500;
    localparam int CONN_US = 2000;
    localparam int RESET_CYC = RESET_MS * (CLK_HZ / 1000);
    localparam int RESET_ACCEPT_CYC = (RESET_ACCEPT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DISC_CYC = (DISC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONN_CYC = CONN_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 24;
    // Decoded line states
    typedef enum logic [2:0] {
        ULSC_SE0, ULSC_J, ULSC_K, ULSC_SE1
    } ulsc_line_t;
endpackage

/* core/ulsc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-wire link; each end drives low-active enables, a pull models idle per speed
interface ulsc_link_if;
    logic a_dp_o, a_dp_oe_n, a_dm_o, a_dm_oe_n;
    logic b_dp_o, b_dp_oe_n, b_dm_o, b_dm_oe_n;
    logic low_speed;
    wire logic dp = !a_dp_oe_n ? a_dp_o : (!b_dp_oe_n ? b_dp_o : !low_speed);
    wire logic dm = !a_dm_oe_n ? a_dm_o : (!b_dm_oe_n ? b_dm_o : low_speed);
    modport port_a (output a_dp_o, a_dp_oe_n, a_dm_o, a_dm_oe_n, input dp, dm, low_speed);
    modport port_b (output b_dp_o, b_dp_oe_n, b_dm_o, b_dm_oe_n, input dp, dm, low_speed);
endinterface
`default_nettype wire

/* core/ulsc_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// Peer end: sends line states only, same transmit sequencer without keep-alive
module ulsc_peer
    import ulsc_pkg::*;
#(
    parameter int RESET_HOLD = ulsc_pkg::RESET_CYC
) (
    input wire logic clk,
    input wire logic reset,
    ulsc_link_if.port_b link,
    input wire logic low_speed,
    input wire logic send_k,
    input wire logic send_eop,
    input wire logic send_reset,
    output logic busy
);
    import ulsc_pkg::*;
    typedef enum {P_IDLE, P_K, P_SE0, P_J, P_RST} ulsc_ptx_t;
    ulsc_ptx_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] bit_cyc;
    if (RESET_HOLD <= 0 || RESET_HOLD >= 2 ** CNT_W) begin
        $error("bad hold");
    end
    assign bit_cyc = low_speed ? CNT_W'(LS_BIT_CYC) : CNT_W'(FS_BIT_CYC);

    // Transmit sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= P_IDLE;
            cnt <= '0;
        end else begin
            case (state)
                P_IDLE: begin
                    cnt <= '0;
                    if (send_reset) state <= P_RST;
                    else if (send_eop) state <= P_SE0;
                    else if (send_k) state <= P_K;
                end
                P_K: if (!send_k) state <= P_IDLE;
                P_SE0: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == 2 * bit_cyc - 1) begin
                        state <= P_J;
                        cnt <= '0;
                    end
                end
                P_J: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == bit_cyc - 1) state <= P_IDLE;
                end
                P_RST: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(RESET_HOLD - 1)) state <= P_IDLE;
                end
                default: state <= P_IDLE;
            endcase
        end
    end

    // Pin drive from state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link.b_dp_oe_n <= 1'b1;
            link.b_dm_oe_n <= 1'b1;
            link.b_dp_o <= 1'b0;
            link.b_dm_o <= 1'b0;
            busy <= 1'b0;
        end else begin
            link.b_dp_oe_n <= (state == P_IDLE);
            link.b_dm_oe_n <= (state == P_IDLE);
            busy <= (state != P_IDLE);
            case (state)
                P_K: begin
                    link.b_dp_o <= low_speed;
                    link.b_dm_o <= !low_speed;
                end
                P_J: begin
                    link.b_dp_o <= !low_speed;
                    link.b_dm_o <= low_speed;
                end
                default: begin
                    link.b_dp_o <= 1'b0;
                    link.b_dm_o <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* core/ulsc_port.sv */
`timescale 1ns/1ns
`default_nettype none
module ulsc_port
    import ulsc_pkg::*;
#(
    parameter int RESET_HOLD = ulsc_pkg::RESET_CYC,
    parameter int RESET_SEEN = ulsc_pkg::RESET_CYC,
    parameter int DISC_TIME = ulsc_pkg::DISC_CYC,
    parameter int CONN_TIME = ulsc_pkg::CONN_CYC
) (
    input wire logic clk,
    input wire logic reset,
    ulsc_link_if.port_a link,
    input wire logic attached_low_speed,
    input wire logic send_k,
    input wire logic send_eop,
    input wire logic send_keep_alive,
    input wire logic send_reset,
    output logic tx_busy,
    output ulsc_pkg::ulsc_line_t line_state,
    output logic se1_seen,
    output logic sop,
    output logic eop,
    output logic reset_early,
    output logic reset_seen,
    output logic disconnected,
    output logic connected
);
    import ulsc_pkg::*;
    typedef enum {T_IDLE, T_K, T_SE0, T_J, T_RST} ulsc_tx_t;
    // Refuse hold, seen and connect timings the counters cannot hold; early accept must not trail full reset
    if (RESET_HOLD <= 0 || RESET_SEEN < RESET_ACCEPT_CYC || DISC_TIME <= 0 || CONN_TIME <= 0
        || RESET_HOLD >= 2 ** CNT_W || RESET_SEEN >= 2 ** CNT_W || CONN_TIME >= 2 ** CNT_W) begin
        $error("bad timing parameter");
    end

    ulsc_tx_t state;
    logic [CNT_W-1:0] tcnt;
    logic tx_ls;
    logic [CNT_W-1:0] tbit;
    logic [2:0] dp_s;
    logic [2:0] dm_s;
    logic dp_q, dm_q;
    ulsc_line_t cur, prev;
    logic [CNT_W-1:0] run;
    logic in_pkt;
    logic se0_bit;
    logic [CNT_W-1:0] rbit;

    // Bit time of the traffic rate tx_ls, held per EOP so keep-alive stays low-speed
    assign tbit = tx_ls ? CNT_W'(LS_BIT_CYC) : CNT_W'(FS_BIT_CYC);
    assign rbit = attached_low_speed ? CNT_W'(LS_BIT_CYC) : CNT_W'(FS_BIT_CYC);

    // Transmit sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= T_IDLE;
            tcnt <= '0;
            tx_ls <= 1'b0;
        end else begin
            case (state)
                T_IDLE: begin
                    tcnt <= '0;
                    tx_ls <= attached_low_speed;
                    if (send_reset) state <= T_RST;
                    else if (send_keep_alive) begin
                        state <= T_SE0;
                        tx_ls <= 1'b1;
                    end else if (send_eop) state <= T_SE0;
                    else if (send_k) state <= T_K;
                end
                T_K: if (!send_k) state <= T_IDLE;
                T_SE0: begin
                    tcnt <= tcnt + 1'b1;
                    if (tcnt == 2 * tbit - 1) begin
                        state <= T_J;
                        tcnt <= '0;
                    end
                end
                T_J: begin
                    tcnt <= tcnt + 1'b1;
                    if (tcnt == tbit - 1) state <= T_IDLE;
                end
                T_RST: begin
                    tcnt <= tcnt + 1'b1;
                    if (tcnt == CNT_W'(RESET_HOLD - 1)) state <= T_IDLE;
                end
                default: state <= T_IDLE;
            endcase
        end
    end

    // Pin drive; J/K from attached speed, not traffic rate
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link.a_dp_oe_n <= 1'b1;
            link.a_dm_oe_n <= 1'b1;
            link.a_dp_o <= 1'b0;
            link.a_dm_o <= 1'b0;
            tx_busy <= 1'b0;
        end else begin
            link.a_dp_oe_n <= (state == T_IDLE);
            link.a_dm_oe_n <= (state == T_IDLE);
            tx_busy <= (state != T_IDLE);
            case (state)
                T_K: begin
                    link.a_dp_o <= attached_low_speed;
                    link.a_dm_o <= !attached_low_speed;
                end
                T_J: begin
                    link.a_dp_o <= !attached_low_speed;
                    link.a_dm_o <= attached_low_speed;
                end
                default: begin
                    link.a_dp_o <= 1'b0;
                    link.a_dm_o <= 1'b0;
                end
            endcase
        end
    end

    // Pin synchronisers; change counts once stages two and three agree
    // Cleared to SE0, so a short SE0 shows after reset; far too short for an EOP
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dp_s <= 3'h0;
            dm_s <= 3'h0;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end else begin
            dp_s <= {dp_s[1:0], link.dp};
            dm_s <= {dm_s[1:0], link.dm};
            if (dp_s[1] == dp_s[2]) dp_q <= dp_s[2];
            if (dm_s[1] == dm_s[2]) dm_q <= dm_s[2];
        end
    end

    // Classify; idle folds into J, resume into K
    always_comb begin
        case ({dp_q, dm_q})
            2'b00: cur = ULSC_SE0;
            2'b11: cur = ULSC_SE1;
            2'b10: cur = attached_low_speed ? ULSC_K : ULSC_J;
            default: cur = attached_low_speed ? ULSC_J : ULSC_K;
        endcase
    end

    // Run length of the current state
    // Saturates instead of wrapping, so a stuck SE0 keeps reset_seen high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev <= ULSC_SE0;
            run <= '0;
        end else begin
            prev <= cur;
            if (cur != prev) run <= '0;
            else if (run != '1) run <= run + 1'b1;
        end
    end

    assign se0_bit = (prev == ULSC_SE0) && (run >= rbit - 1);

    // Receive events and status
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_state <= ULSC_SE0;
            se1_seen <= 1'b0;
            sop <= 1'b0;
            eop <= 1'b0;
            in_pkt <= 1'b0;
            reset_early <= 1'b0;
            reset_seen <= 1'b0;
            disconnected <= 1'b1;
            connected <= 1'b0;
        end else begin
            line_state <= cur;
            se1_seen <= (cur == ULSC_SE1);
            sop <= !in_pkt && prev == ULSC_J && cur == ULSC_K;
            eop <= se0_bit && cur == ULSC_J;
            // Only the first J-to-K outside a packet opens one; data Ks inside do not
            if (!in_pkt && prev == ULSC_J && cur == ULSC_K) in_pkt <= 1'b1;
            else if (se0_bit && cur == ULSC_J) in_pkt <= 1'b0;
            reset_early <= cur == ULSC_SE0 && run >= CNT_W'(RESET_ACCEPT_CYC - 1);
            reset_seen <= cur == ULSC_SE0 && run >= CNT_W'(RESET_SEEN - 1);
            if (cur == ULSC_SE0 && prev == ULSC_SE0 && run >= CNT_W'(DISC_TIME - 1)) begin
                disconnected <= 1'b1;
                connected <= 1'b0;
            end else if (cur == ULSC_J && prev == ULSC_J && run >= CNT_W'(CONN_TIME - 1)
                && disconnected) begin
                disconnected <= 1'b0;
                connected <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/ulsc_link_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// Watches both ends' pin drive; counts states so lengths are judged when they end
module ulsc_link_checker
    import ulsc_pkg::*;
#(
    parameter int HOLD = ulsc_pkg::RESET_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic a_dp_o,
    input wire logic a_dp_oe_n,
    input wire logic a_dm_o,
    input wire logic a_dm_oe_n,
    input wire logic b_dp_o,
    input wire logic b_dp_oe_n,
    input wire logic b_dm_o,
    input wire logic b_dm_oe_n,
    input wire logic low_speed
);
    logic a_se0, b_se0, a_j, b_j;
    int a_se0_n, b_se0_n, a_j_n, eop_se0, bit_j;
    // Driven states; J follows the attached speed
    assign a_se0 = !a_dp_oe_n && !a_dp_o && !a_dm_o;
    assign b_se0 = !b_dp_oe_n && !b_dp_o && !b_dm_o;
    assign a_j = !a_dp_oe_n && (a_dp_o == !low_speed) && (a_dm_o == low_speed);
    assign b_j = !b_dp_oe_n && (b_dp_o == !low_speed) && (b_dm_o == low_speed);
    assign eop_se0 = low_speed ? 2 * LS_BIT_CYC : 2 * FS_BIT_CYC;
    assign bit_j = low_speed ? LS_BIT_CYC : FS_BIT_CYC;
    // Run lengths, cleared as soon as the state is left
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            a_se0_n <= 0;
            b_se0_n <= 0;
            a_j_n <= 0;
        end else begin
            a_se0_n <= a_se0 ? a_se0_n + 1 : 0;
            b_se0_n <= b_se0 ? b_se0_n + 1 : 0;
            a_j_n <= a_j ? a_j_n + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_A_BOTH: assert property (a_dp_oe_n == a_dm_oe_n)
        else $error("port end drives one line alone");
    AST_B_BOTH: assert property (b_dp_oe_n == b_dm_oe_n)
        else $error("peer end drives one line alone");
    AST_A_EOP_SE0: assert property ((!a_dp_oe_n && !a_se0 && a_se0_n != 0)
        |-> a_se0_n == eop_se0)
        else $error("port end-of-packet low phase has wrong length");
    AST_B_EOP_SE0: assert property ((!b_dp_oe_n && !b_se0 && b_se0_n != 0)
        |-> b_se0_n == eop_se0)
        else $error("peer end-of-packet low phase has wrong length");
    AST_A_EOP_J: assert property ((a_dp_oe_n && a_j_n != 0) |-> a_j_n == bit_j)
        else $error("port closing idle level has wrong length");
    AST_A_RESET: assert property ((a_dp_oe_n && a_se0_n != 0) |-> a_se0_n == HOLD)
        else $error("port bus reset has wrong length");
    AST_B_RESET: assert property ((b_dp_oe_n && b_se0_n != 0) |-> b_se0_n == HOLD)
        else $error("peer bus reset has wrong length");
    AST_A_J_AFTER: assert property (($fell(a_se0) && !a_dp_oe_n) |-> a_j)
        else $error("port level after low phase is not J of this speed");
    AST_B_J_AFTER: assert property (($fell(b_se0) && !b_dp_oe_n) |-> b_j)
        else $error("peer level after low phase is not J of this speed");
    cover property ($fell(a_se0) && !a_dp_oe_n);
    cover property ($fell(b_se0) && !b_dp_oe_n);
    cover property (a_dp_oe_n && a_se0_n == HOLD);
endmodule
`default_nettype wire

/* dv/tb_usb_ls_fs_line_state_codec.sv */
`timescale 1ns/1ns
`default_nettype none
// Port and peer face each other; the peer's traffic is judged at the port's outputs
module tb_usb_ls_fs_line_state_codec;
    import ulsc_pkg::*;
    localparam int HOLD = 200;
    localparam int AK = 0, AE = 1, AKA = 2, AR = 3, BK = 4, BE = 5, BR = 6;
    logic clk, reset, ls, watch, a_busy, b_busy, se1, sop, eop, r_early, r_seen, disc, conn;
    logic seen_d, conn_d;
    logic [6:0] req;
    ulsc_line_t state;
    logic [2:0] q[$];
    int num_errors = 0, n_checks = 0, cycles = 0, n, seed;
    ulsc_link_if ulsc_link_if_i();
    assign ulsc_link_if_i.low_speed = ls;
    ulsc_port #(.RESET_HOLD(HOLD), .RESET_SEEN(150), .CONN_TIME(100)) ulsc_port_i (
        .clk(clk), .reset(reset), .link(ulsc_link_if_i), .attached_low_speed(ls),
        .send_k(req[AK]), .send_eop(req[AE]), .send_keep_alive(req[AKA]),
        .send_reset(req[AR]), .tx_busy(a_busy), .line_state(state), .se1_seen(se1),
        .sop(sop), .eop(eop), .reset_early(r_early), .reset_seen(r_seen),
        .disconnected(disc), .connected(conn));
    ulsc_peer #(.RESET_HOLD(HOLD)) ulsc_peer_i (
        .clk(clk), .reset(reset), .link(ulsc_link_if_i), .low_speed(ls),
        .send_k(req[BK]), .send_eop(req[BE]), .send_reset(req[BR]), .busy(b_busy));
    ulsc_link_checker #(.HOLD(HOLD)) ulsc_link_checker_i (
        .clk(clk), .reset(reset),
        .a_dp_o(ulsc_link_if_i.a_dp_o), .a_dp_oe_n(ulsc_link_if_i.a_dp_oe_n),
        .a_dm_o(ulsc_link_if_i.a_dm_o), .a_dm_oe_n(ulsc_link_if_i.a_dm_oe_n),
        .b_dp_o(ulsc_link_if_i.b_dp_o), .b_dp_oe_n(ulsc_link_if_i.b_dp_oe_n),
        .b_dm_o(ulsc_link_if_i.b_dm_o), .b_dm_oe_n(ulsc_link_if_i.b_dm_oe_n),
        .low_speed(ls));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [2:0] act, input logic [2:0] exp);
        n_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask
    // Oldest note against the event that just showed; empty queue means unexpected
    task automatic take(input logic [2:0] code);
        logic [2:0] exp;
        exp = (q.size() != 0) ? q.pop_front() : 3'h0;
        check(code, exp);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watcher on the port's receive outputs; off while the port hears itself
    always @(posedge clk) begin
        seen_d <= r_seen;
        conn_d <= conn;
        if (!reset && watch) begin
            if (se1 !== 1'b0) check({2'h0, se1}, 3'h0);
            if (sop === 1'b1) take(3'h1);
            if (eop === 1'b1) take(3'h2);
            if (r_seen === 1'b1 && seen_d === 1'b0) begin
                take(3'h3);
                check({2'h0, r_early}, 3'h1);
                check({2'h0, disc}, 3'h1);
                check(state, ULSC_SE0);
            end
            if (conn === 1'b1 && conn_d === 1'b0) take(3'h4);
        end
    end
    // Hang guard, well above the expected few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            num_errors++;
            summarize();
        end
    end
    // Requests only when both sequencers rest, plus one spare cycle
    task automatic idle();
        repeat (2) @(posedge clk);
        while (a_busy !== 1'b0 || b_busy !== 1'b0) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        req[b] <= 1'b1;
        @(posedge clk);
        req[b] <= 1'b0;
        idle();
    endtask
    task automatic hold_k(input int b);
        @(posedge clk);
        req[b] <= 1'b1;
        repeat (10) @(posedge clk);
        if (b == BK) check(state, ULSC_K);
        repeat (n) @(posedge clk);
        req[b] <= 1'b0;
        idle();
    endtask
    task automatic drain();
        repeat (500) if (q.size() != 0) @(posedge clk);
        check(q.size() == 0, 3'h1);
    endtask
    initial begin
        seed = $urandom(32'hF5F1);
        reset = 1'b1;
        ls = 1'b0;
        watch = 1'b1;
        req = '0;
        q.push_back(3'h4);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        drain();
        for (int s = 0; s < 2; s++) begin
            if (s == 1) begin
                // Re-attach at the other speed; a live swap would read as a false K
                reset <= 1'b1;
                ls <= 1'b1;
                repeat (6) @(posedge clk);
                reset <= 1'b0;
                q.push_back(3'h4);
                drain();
            end
            repeat (10) @(posedge clk);
            check(state, ULSC_J);
            n = 2 + $urandom_range(20);
            q.push_back(3'h1);
            hold_k(BK);
            q.push_back(3'h2);
            pulse(BE);
            drain();
            // Long SE0 then idle J also meets the end-of-packet rule
            q.push_back(3'h3);
            q.push_back(3'h2);
            q.push_back(3'h4);
            pulse(BR);
            drain();
            watch <= 1'b0;
            hold_k(AK);
            pulse(AE);
            if (s == 1) pulse(AKA);
            pulse(AR);
            repeat (10) @(posedge clk);
            watch <= 1'b1;
            q.push_back(3'h4);
            drain();
        end
        summarize();
    end
endmodule
`default_nettype wire
